/* File: rtl/ids_diag.sv */
// Diagnostics core: self-test, memory test and status flags
`timescale 1ns/100ps
module ids_diag
#(
   parameter int SAMPLE_CYCLES = ids_pkg::SAMPLE_CYCLES,
   parameter int SETTLE_CYCLES = ids_pkg::SETTLE_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        mosi,
   output      logic        miso,
   input  wire logic [5:0]  sensor_st_fail,
   input  wire logic [1:0]  alarm_active,
   input  wire logic        overrange,
   input  wire logic        supply_high,
   input  wire logic        supply_low,
   input  wire logic        flash_update_fail,
   input  wire logic        flash_wr_en,
   input  wire logic [3:0]  flash_waddr,
   input  wire logic [15:0] flash_wdata,
   output      logic        stim_pos,
   output      logic        stim_neg
);
   // ****************************************
   // Declarations
   // ****************************************
   ids_link_if lnk ();

   logic [13:0]     pin_s1_q;
   logic [13:0]     pin_s2_q;
   logic [2:0]      tog_q;
   logic            link_rst_q;
   logic            word_stb;
   logic [15:0]     rx;
   logic            stat_rd;
   logic [15:0]     ctrl_q;
   logic [15:0]     ctrl_d;
   logic [15:0]     stat_q;
   logic [15:0]     stat_d;
   logic [15:0]     cond;
   logic [15:0]     set;
   logic [15:0]     tx_q;
   logic [14:0]     smp_cnt_q;
   logic            tick_q;
   logic            res_upd_q;
   ids_pkg::ids_st_t st_q;
   logic [20:0]     settle_q;
   logic [5:0]      st_res_q;
   ids_pkg::ids_mt_t mt_q;
   logic [3:0]      raddr_q;
   logic [15:0]     sum_q;
   logic [15:0]     rdata;
   logic            cksum_fail_q;
   logic            stim_pos_q;
   logic            stim_neg_q;
   logic [5:0]      sens_s;
   logic [1:0]      alarm_s;
   logic            spi_fail;
   logic            miso_q_w;

   function automatic logic hit(input logic [15:0] w, input logic [6:0] a);
      hit = (w[14:8] == a);
   endfunction

   assign sens_s   = pin_s2_q[13:8];
   assign alarm_s  = pin_s2_q[7:6];
   assign spi_fail = pin_s2_q[1] & pin_s2_q[0];
   assign word_stb = tog_q[2] ^ tog_q[1];
   assign rx       = lnk.rx_word;
   assign stat_rd  = word_stb & ~rx[ids_pkg::FRAME_WR_BIT] & hit(rx, ids_pkg::ADDR_STATUS);
   assign lnk.link_rst = link_rst_q;
   assign lnk.tx_word  = tx_q;
   assign miso     = miso_q_w;
   assign stim_pos = stim_pos_q;
   assign stim_neg = stim_neg_q;

   // ****************************************
   // Submodules
   // ****************************************
   ids_link u_link
   (
      .sclk   (sclk),
      .cs_n   (cs_n),
      .mosi   (mosi),
      .miso_q (miso_q_w),
      .lnk    (lnk.phy)
   );

   ids_flash_mem u_mem
   (
      .clk     (clk),
      .wr_en   (flash_wr_en),
      .waddr   (flash_waddr),
      .wdata   (flash_wdata),
      .raddr   (raddr_q),
      .rdata_q (rdata)
   );

   // ****************************************
   // Synchronisers and link reset
   // ****************************************
   always_ff @(posedge clk)
   begin
      link_rst_q <= ~rst_n;
      pin_s1_q   <= {sensor_st_fail, alarm_active, overrange, supply_high, supply_low,
                     flash_update_fail, cs_n, lnk.partial};
      pin_s2_q   <= pin_s1_q;
      tog_q      <= {tog_q[1], tog_q[0], lnk.rx_tog};
      if (!rst_n)
      begin
         tog_q <= 3'h0;
      end
   end

   // ****************************************
   // Sample tick
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n || smp_cnt_q == 15'(SAMPLE_CYCLES - 1))
      begin
         smp_cnt_q <= 15'h0000;
      end
      else
      begin
         smp_cnt_q <= smp_cnt_q + 15'h0001;
      end
      tick_q <= rst_n && smp_cnt_q == 15'(SAMPLE_CYCLES - 1);
   end

   // ****************************************
   // misc_control
   // ****************************************
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (st_q == ids_pkg::ST_JUDGE)
      begin
         ctrl_d[ids_pkg::CTRL_SELFTEST] = 1'b0;
      end
      if (mt_q == ids_pkg::MT_CHECK)
      begin
         ctrl_d[ids_pkg::CTRL_MEMTEST] = 1'b0;
      end
      if (word_stb && rx[ids_pkg::FRAME_WR_BIT])
      begin
         if (hit(rx, ids_pkg::ADDR_CTRL_LO))
         begin
            ctrl_d[7:0] = rx[7:0] & ids_pkg::CTRL_WR_MASK[7:0];
         end
         if (hit(rx, ids_pkg::ADDR_CTRL_HI))
         begin
            ctrl_d[9:8]   = rx[1:0];
            ctrl_d[11:10] = ctrl_d[11:10] | rx[3:2];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      ctrl_q <= rst_n ? ctrl_d : ids_pkg::CTRL_RESET;
   end

   // ****************************************
   // Automatic self-test
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_q     <= ids_pkg::ST_IDLE;
         settle_q <= 21'h00_0000;
         st_res_q <= 6'h00;
      end
      else
      begin
         case (st_q)
            ids_pkg::ST_IDLE:
            begin
               settle_q <= 21'h00_0000;
               if (ctrl_q[ids_pkg::CTRL_SELFTEST])
               begin
                  st_q <= ids_pkg::ST_STIM;
               end
            end
            ids_pkg::ST_STIM:
            begin
               settle_q <= settle_q + 21'h00_0001;
               if (settle_q == 21'(SETTLE_CYCLES - 1))
               begin
                  st_q <= ids_pkg::ST_JUDGE;
               end
            end
            ids_pkg::ST_JUDGE:
            begin
               st_res_q <= sens_s;
               st_q     <= ids_pkg::ST_IDLE;
            end
            default:
            begin
               st_q <= ids_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Flash checksum test
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         mt_q         <= ids_pkg::MT_IDLE;
         raddr_q      <= 4'h0;
         sum_q        <= 16'h0000;
         cksum_fail_q <= 1'b0;
      end
      else
      begin
         case (mt_q)
            ids_pkg::MT_IDLE:
            begin
               raddr_q <= 4'h0;
               sum_q   <= 16'h0000;
               if (ctrl_q[ids_pkg::CTRL_MEMTEST])
               begin
                  mt_q <= ids_pkg::MT_READ;
               end
            end
            ids_pkg::MT_READ:
            begin
               raddr_q <= raddr_q + 4'h1;
               if (raddr_q != 4'h0)
               begin
                  sum_q <= sum_q + rdata;
               end
               if (raddr_q == 4'hF)
               begin
                  mt_q <= ids_pkg::MT_CHECK;
               end
            end
            ids_pkg::MT_CHECK:
            begin
               cksum_fail_q <= (sum_q != rdata);
               mt_q         <= ids_pkg::MT_IDLE;
            end
            default:
            begin
               mt_q <= ids_pkg::MT_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Stimulus outputs
   // ****************************************
   always_ff @(posedge clk)
   begin
      stim_pos_q <= rst_n && (ctrl_q[ids_pkg::CTRL_STIM_POS] || st_q == ids_pkg::ST_STIM);
      stim_neg_q <= rst_n && ctrl_q[ids_pkg::CTRL_STIM_NEG];
      res_upd_q  <= rst_n && (st_q == ids_pkg::ST_JUDGE || mt_q == ids_pkg::MT_CHECK);
   end

   // ****************************************
   // diagnostic_status
   // ****************************************
   always_comb
   begin
      // Accelerometer failures in 15 to 13
      // Gyroscope failures in 12 to 10
      cond[15:ids_pkg::SB_SENSOR_LO]         = st_res_q;
      cond[9:ids_pkg::SB_ALARM_LO]           = alarm_s;
      cond[ids_pkg::SB_UNUSED]               = 1'b0;
      cond[ids_pkg::SB_CHECKSUM]             = cksum_fail_q;
      cond[ids_pkg::SB_ST_ERROR]             = |st_res_q;
      cond[ids_pkg::SB_OVERRANGE]            = pin_s2_q[5];
      cond[ids_pkg::SB_SPI_FAIL]             = spi_fail;
      cond[ids_pkg::SB_FLASH_UPD]            = pin_s2_q[2];
      cond[ids_pkg::SB_SUPPLY_HI]            = pin_s2_q[4];
      cond[ids_pkg::SB_SUPPLY_LO]            = pin_s2_q[3];
      set    = cond & {16{tick_q | res_upd_q}};
      stat_d = (stat_q & ~{16{stat_rd}}) | set;
      stat_d[1:0] = stat_d[1:0] & cond[1:0];
   end

   always_ff @(posedge clk)
   begin
      stat_q <= rst_n ? stat_d : ids_pkg::STATUS_RESET;
   end

   // ****************************************
   // Read answer
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tx_q <= 16'h0000;
      end
      else if (word_stb && !rx[ids_pkg::FRAME_WR_BIT])
      begin
         if (stat_rd)
         begin
            tx_q <= stat_q;
         end
         else if (hit(rx, ids_pkg::ADDR_CTRL_LO))
         begin
            tx_q <= ctrl_q;
         end
         else
         begin
            tx_q <= 16'h0000;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_selftest_self_clear: assert property (st_q == ids_pkg::ST_JUDGE |=> !ctrl_q[10])
      else $error("self-test bit not cleared");
   chk_selftest_result: assert property (st_q == ids_pkg::ST_JUDGE |=> st_res_q == $past(sens_s))
      else $error("self-test result not recorded");
   chk_stim_neg_follow: assert property (ctrl_q[9] |=> stim_neg)
      else $error("negative stimulus missing");
   chk_memtest_verdict: assert property (mt_q == ids_pkg::MT_CHECK |=>
      cksum_fail_q == ($past(sum_q) != $past(rdata)))
      else $error("checksum verdict wrong");
   chk_memtest_clear: assert property (mt_q == ids_pkg::MT_CHECK |=> !ctrl_q[11])
      else $error("memory test bit not cleared");
   chk_read_clear: assert property (stat_rd |=> (stat_q & ~$past(set)) == 16'h0000)
      else $error("flags survive status read");
   chk_fault_reset: assert property (tick_q |=>
      (stat_q[15:2] & $past(cond[15:2])) == $past(cond[15:2]))
      else $error("persisting fault not set again");
   chk_supply_drop: assert property (!cond[1] |=> !stat_q[1])
      else $error("supply flag held without cause");
   chk_unused_zero: assert property (!stat_q[7])
      else $error("unused status bit set");
   chk_read_capture: assert property (stat_rd |=> tx_q == $past(stat_q))
      else $error("answer not prior flags");
   chk_st_summary: assert property (res_upd_q && |st_res_q |=> stat_q[5])
      else $error("summary flag missing");
endmodule

/* File: rtl/ids_flash_mem.sv */
// Flash image store with registered read data
`timescale 1ns/100ps
module ids_flash_mem
(
   input  wire logic                         clk,
   input  wire logic                         wr_en,
   input  wire logic [ids_pkg::FLASH_AW-1:0] waddr,
   input  wire logic [ids_pkg::FLASH_DW-1:0] wdata,
   input  wire logic [ids_pkg::FLASH_AW-1:0] raddr,
   output      logic [ids_pkg::FLASH_DW-1:0] rdata_q
);
   logic [ids_pkg::FLASH_DW-1:0] mem [2**ids_pkg::FLASH_AW];

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      rdata_q <= mem[raddr];
   end
endmodule

/* File: rtl/ids_link.sv */
// Serial link engine on the link clock, mode 3, 16-bit frames
`timescale 1ns/100ps
module ids_link
(
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic mosi,
   output      logic miso_q,
   ids_link_if.phy   lnk
);
   logic [3:0]  bit_cnt_q;
   logic [14:0] rx_sh_q;
   logic [14:0] tx_sh_q;

   // Bit count restarts with every frame
   always_ff @(posedge sclk or posedge cs_n or posedge lnk.link_rst)
   begin
      if (cs_n || lnk.link_rst)
      begin
         bit_cnt_q <= 4'h0;
      end
      else
      begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end

   // Receive shift and word hand-off by toggle
   always_ff @(posedge sclk or posedge lnk.link_rst)
   begin
      if (lnk.link_rst)
      begin
         rx_sh_q     <= 15'h0000;
         lnk.rx_word <= 16'h0000;
         lnk.rx_tog  <= 1'b0;
         lnk.partial <= 1'b0;
      end
      else
      begin
         rx_sh_q     <= {rx_sh_q[13:0], mosi};
         lnk.partial <= (bit_cnt_q != 4'hF);
         if (bit_cnt_q == 4'hF)
         begin
            lnk.rx_word <= {rx_sh_q, mosi};
            lnk.rx_tog  <= ~lnk.rx_tog;
         end
      end
   end

   // Transmit shift, loaded at the first falling edge of a word
   always_ff @(negedge sclk or posedge lnk.link_rst)
   begin
      if (lnk.link_rst)
      begin
         {miso_q, tx_sh_q} <= 16'h0000;
      end
      else if (bit_cnt_q == 4'h0)
      begin
         {miso_q, tx_sh_q} <= lnk.tx_word;
      end
      else
      begin
         {miso_q, tx_sh_q} <= {tx_sh_q, 1'b0};
      end
   end
endmodule

/* File: rtl/ids_link_if.sv */
// Signals between the core and the serial link engine
`timescale 1ns/100ps
interface ids_link_if;
   logic        link_rst;
   logic [15:0] rx_word;
   logic        rx_tog;
   logic        partial;
   logic [15:0] tx_word;

   modport core (output link_rst, output tx_word, input rx_word, input rx_tog, input partial);
   modport phy  (input link_rst, input tx_word, output rx_word, output rx_tog, output partial);
endinterface

/* File: rtl/ids_pkg.sv */
// Shared constants and types of the inertial diagnostics block
package ids_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ        = 25_000_000;
   localparam int SAMPLE_HZ_X10 = 8192;
   localparam int SAMPLE_CYCLES = CLK_HZ * 10 / SAMPLE_HZ_X10;
   localparam int SETTLE_MS     = 50;
   localparam int SETTLE_CYCLES = CLK_HZ / 1000 * SETTLE_MS;

   // ****************************************
   // Serial frame and register map
   // ****************************************
   localparam int         WORD_W       = 16;
   localparam int         FRAME_WR_BIT = 15;
   localparam logic [6:0] ADDR_CTRL_LO = 7'h34;
   localparam logic [6:0] ADDR_CTRL_HI = 7'h35;
   localparam logic [6:0] ADDR_STATUS  = 7'h3C;

   // ****************************************
   // misc_control fields
   // ****************************************
   localparam int          CTRL_MEMTEST  = 11;
   localparam int          CTRL_SELFTEST = 10;
   localparam int          CTRL_STIM_NEG = 9;
   localparam int          CTRL_STIM_POS = 8;
   localparam logic [15:0] CTRL_RESET    = 16'h0006;
   localparam logic [15:0] CTRL_WR_MASK  = 16'h0FC7;

   // ****************************************
   // diagnostic_status fields
   // ****************************************
   localparam int          SB_SENSOR_LO = 10;
   localparam int          SB_ALARM_LO  = 8;
   localparam int          SB_UNUSED    = 7;
   localparam int          SB_CHECKSUM  = 6;
   localparam int          SB_ST_ERROR  = 5;
   localparam int          SB_OVERRANGE = 4;
   localparam int          SB_SPI_FAIL  = 3;
   localparam int          SB_FLASH_UPD = 2;
   localparam int          SB_SUPPLY_HI = 1;
   localparam int          SB_SUPPLY_LO = 0;
   localparam logic [15:0] STATUS_RESET = 16'h0000;

   // ****************************************
   // Flash image store
   // ****************************************
   localparam int FLASH_AW = 4;
   localparam int FLASH_DW = 16;

   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_STIM = 2'b01, ST_JUDGE = 2'b11} ids_st_t;
   typedef enum logic [1:0] {MT_IDLE = 2'b00, MT_READ = 2'b01, MT_CHECK = 2'b11} ids_mt_t;
endpackage

/* File: testbench/ids_diag_bench.sv */
// Self-checking bench of the inertial diagnostics block
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
      end \
   end
module ids_diag_bench;
   logic        clk;
   logic        rst_n;
   logic        sclk;
   logic        cs_n;
   logic        mosi;
   logic        miso;
   logic [5:0]  st_fail;
   logic [1:0]  alarm;
   logic        ovr;
   logic        sup_hi;
   logic        sup_lo;
   logic        fl_fail;
   logic        fl_we;
   logic [3:0]  fl_wa;
   logic [15:0] fl_wd;
   logic [15:0] rd;
   logic        stim_pos;
   logic        stim_neg;
   int          errors;
   int          n_compared;

   // ****************************************
   // Design and host
   // ****************************************
   ids_diag #(.SAMPLE_CYCLES(20), .SETTLE_CYCLES(10)) u_dut
   (
      .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .sensor_st_fail(st_fail), .alarm_active(alarm), .overrange(ovr),
      .supply_high(sup_hi), .supply_low(sup_lo), .flash_update_fail(fl_fail),
      .flash_wr_en(fl_we), .flash_waddr(fl_wa), .flash_wdata(fl_wd),
      .stim_pos(stim_pos), .stim_neg(stim_neg)
   );
   ids_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic rd_reg(input logic [6:0] a, output logic [15:0] r);
      u_host.xfer({1'b0, a, 8'h00}, 16, r);
      u_host.xfer(16'h0000, 16, r);
   endtask

   task automatic wr(input logic [15:0] w);
      logic [15:0] r;
      u_host.xfer(w, 16, r);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wait_ctrl(input int b);
      logic [15:0] r;
      for (int k = 0; k < 20; k++)
      begin
         rd_reg(ids_pkg::ADDR_CTRL_LO, r);
         if (r[b] === 1'b0)
            break;
      end
      `CHK("ctrl done bit", 1'b0, r[b])
   endtask

   task automatic load_image(input logic [15:0] last);
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk);
         fl_we <= 1'b1;
         fl_wa <= 4'(i);
         fl_wd <= (i == 15) ? last : 16'(i + 1);
      end
      @(posedge clk);
      fl_we <= 1'b0;
   endtask

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      #3_000_000;
      errors++;
      give_verdict();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      errors = 0;
      n_compared = 0;
      rst_n = 1'b0;
      {st_fail, alarm, ovr, sup_hi, sup_lo, fl_fail, fl_we} = '0;
      fl_wa = 4'h0;
      fl_wd = 16'h0000;
      idle(12);
      rst_n <= 1'b1;
      idle(6);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      `CHK("status reset", ids_pkg::STATUS_RESET, rd)
      rd_reg(ids_pkg::ADDR_CTRL_LO, rd);
      `CHK("ctrl reset", ids_pkg::CTRL_RESET, rd)
      u_host.stim_step(16'hB502, rd);
      `CHK("stim neg", 2'b10, {stim_neg, stim_pos})
      u_host.stim_step(16'hB501, rd);
      `CHK("stim pos", 2'b01, {stim_neg, stim_pos})
      u_host.stim_step(16'hB500, rd);
      `CHK("stim off", 2'b00, {stim_neg, stim_pos})
      u_host.xfer(16'hFFFF, 8, rd);
      idle(30);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      `CHK("partial frame", 16'h0008, rd)
      @(posedge clk);
      {alarm, ovr, fl_fail, sup_hi} <= {2'b10, 1'b1, 1'b1, 1'b1};
      idle(30);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      `CHK("conditions", 16'h0216, rd)
      sup_hi <= 1'b0;
      idle(30);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      `CHK("persist", 16'h0214, rd)
      {alarm, ovr, fl_fail} <= '0;
      idle(30);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      idle(30);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      `CHK("read clear", 16'h0000, rd)
      sup_lo <= 1'b1;
      idle(30);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      `CHK("supply low", 16'h0001, rd)
      idle(30);
      sup_lo <= 1'b0;
      idle(10);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      `CHK("supply drop", 16'h0000, rd)
      load_image(16'h0079);
      wr(16'hB508);
      wait_ctrl(ids_pkg::CTRL_MEMTEST);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      `CHK("checksum fail", 16'h0040, rd)
      load_image(16'h0078);
      wr(16'hB508);
      wait_ctrl(ids_pkg::CTRL_MEMTEST);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      idle(30);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      `CHK("checksum pass", 16'h0000, rd)
      st_fail <= 6'b101001;
      wr(16'hB504);
      wait_ctrl(ids_pkg::CTRL_SELFTEST);
      rd_reg(ids_pkg::ADDR_STATUS, rd);
      `CHK("self-test", 16'hA420, rd)
      give_verdict();
   end
endmodule

/* File: testbench/ids_host_model.sv */
// Host processor model on the serial link
`timescale 1ns/100ps
module ids_host_model
#(
   parameter int SETTLE_NS = 2000
)
(
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   // ****************************************
   // Idle levels
   // ****************************************
   initial
   begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // ****************************************
   // Word transfer, mode 3, MSB first
   // ****************************************
   task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
      r = 16'h0000;
      cs_n = 1'b0;
      for (int i = 15; i > 15 - nbits; i--)
      begin
         #62.5 sclk = 1'b0;
         mosi = w[i];
         #62.5 sclk = 1'b1;
         r[i] = miso;
      end
      #62.5 cs_n = 1'b1;
      mosi = ~mosi;
      #500;
   endtask

   // ****************************************
   // Manual self-test step
   // ****************************************
   // command, settle, rate read
   task automatic stim_step(input logic [15:0] cmd, output logic [15:0] r);
      xfer(cmd, 16, r);
      #(SETTLE_NS);
      xfer(16'h0400, 16, r);
      xfer(16'h0000, 16, r);
   endtask
endmodule
